// >>> hdl/crc_engine_params.svh
// Register offsets, field positions, reset values and codes for the CRC engine
`ifndef CRC_ENGINE_PARAMS_SVH
`define CRC_ENGINE_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CRC_ADDR_W          8
`define OFS_CRC_CONTROL     8'h00
`define OFS_DATA_MASK       8'h04
`define OFS_POLYNOMIAL      8'h08
`define OFS_LFSR_STATE      8'h0c
`define OFS_REM_MASK        8'h10
`define OFS_REMAINDER       8'h14
`define OFS_STATUS          8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_DATA_REVERSE    0
`define BIT_REMAINDER_BIT_ORDER_FLIP     8
`define BIT_STAT_BUSY       0
`define BIT_STAT_PENDING    1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CONTROL         32'h0000_0000
`define RST_DATA_MASK       8'h00
`define RST_POLYNOMIAL      32'h0000_0000
`define RST_LFSR_STATE      32'h0000_0000
`define RST_REM_MASK        32'h0000_0000

// ----------------------------------------------------------------
// Instruction and bus codes, and the load FIFO depth
// ----------------------------------------------------------------
`define OPCODE_CRC          8'h58
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define FIFO_DEPTH          32

`endif

// >>> hdl/crc_engine_pkg.sv
// Types shared by the CRC engine files
package crc_engine_pkg;

    // ----------------------------------------------------------------
    // Stream carrier and engine states
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } stream_item_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } crc_state_t;

endpackage

// >>> hdl/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RST,
    // Fill side
    input  wire logic             IN_VALID,
    output logic                  IN_READY,
    input  wire logic [WIDTH-1:0] IN_DATA,
    // Drain side
    output logic                  OUT_VALID,
    input  wire logic             OUT_READY,
    output logic [WIDTH-1:0]      OUT_DATA
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign IN_READY  = (count != (AW+1)'(DEPTH));
    assign OUT_VALID = (count != '0);
    assign OUT_DATA  = mem[rd_ptr];
    assign push      = IN_VALID & IN_READY;
    assign pop       = OUT_VALID & OUT_READY;

    always_comb begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage has no reset; only the pointers and the count define what is valid
    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr] <= IN_DATA;
        end
    end

endmodule

// >>> hdl/crc_engine.sv
// Byte stream CRC engine with AXI4-Lite registers and instruction port
`include "crc_engine_params.svh"

module crc_engine (
    // Clock and reset
    input  wire logic                      CLK,
    input  wire logic                      RST,
    // AXI4-Lite write address and data
    input  wire logic                      AWVALID,
    output logic                           AWREADY,
    input  wire logic [`CRC_ADDR_W-1:0]    AWADDR,
    input  wire logic                      WVALID,
    output logic                           WREADY,
    input  wire logic [31:0]               WDATA,
    input  wire logic [3:0]                WSTRB,
    // AXI4-Lite write response
    output logic                           BVALID,
    input  wire logic                      BREADY,
    output logic [1:0]                     BRESP,
    // AXI4-Lite read
    input  wire logic                      ARVALID,
    output logic                           ARREADY,
    input  wire logic [`CRC_ADDR_W-1:0]    ARADDR,
    output logic                           RVALID,
    input  wire logic                      RREADY,
    output logic [31:0]                    RDATA,
    output logic [1:0]                     RRESP,
    // Instruction port
    input  wire logic                      INSTR_VALID,
    output logic                           INSTR_READY,
    input  wire logic [31:0]               INSTR_WORD,
    output logic                           INSTR_DONE,
    output logic                           BUSY,
    // Load stream
    input  wire logic                      BYTE_VALID,
    output logic                           BYTE_READY,
    input  wire crc_engine_pkg::stream_item_t BYTE_ITEM
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rev32(input logic [31:0] v);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) r[i] = v[31-i];
        return r;
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7-i];
        return r;
    endfunction

    function automatic logic [31:0] crc_byte(input logic [31:0] s,
                                             input logic [7:0]  d,
                                             input logic [31:0] p);
        logic [31:0] t;
        logic        fb;
        t = s;
        for (int i = 7; i >= 0; i--) begin
            fb = t[31] ^ d[i];
            t  = {t[30:0], 1'b0};
            if (fb) t = t ^ p;
        end
        return t;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
        return r;
    endfunction

    function automatic logic mapped(input logic [`CRC_ADDR_W-1:0] a);
        return a == `OFS_CRC_CONTROL || a == `OFS_DATA_MASK ||
               a == `OFS_POLYNOMIAL  || a == `OFS_LFSR_STATE ||
               a == `OFS_REM_MASK    || a == `OFS_REMAINDER ||
               a == `OFS_STATUS;
    endfunction

    // ----------------------------------------------------------------
    // Load FIFO
    // ----------------------------------------------------------------
    crc_engine_pkg::stream_item_t fifo_item;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_fire;

    byte_fifo #(.WIDTH(9), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .CLK       (CLK),
        .RST       (RST),
        .IN_VALID  (BYTE_VALID),
        .IN_READY  (BYTE_READY),
        .IN_DATA   (BYTE_ITEM),
        .OUT_VALID (fifo_valid),
        .OUT_READY (fifo_ready),
        .OUT_DATA  (fifo_item)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic                   aw_held, next_aw_held;
    logic                   w_held, next_w_held;
    logic [`CRC_ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0]            w_data, next_w_data;
    logic [3:0]             w_strb, next_w_strb;
    logic                   bvalid, next_bvalid;
    logic [1:0]             bresp, next_bresp;
    logic                   wr_fire;

    assign AWREADY = !aw_held;
    assign WREADY  = !w_held;
    assign BVALID  = bvalid;
    assign BRESP   = bresp;
    assign wr_fire = aw_held & w_held & !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (AWVALID && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = AWADDR;
        end
        if (WVALID && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = WDATA;
            next_w_strb = WSTRB;
        end
        if (bvalid && BREADY) next_bvalid = 1'b0;
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
        end
    end

    // ----------------------------------------------------------------
    // Engine core and configuration
    // ----------------------------------------------------------------
    crc_engine_pkg::crc_state_t state, next_state;
    logic [31:0] control, next_control;
    logic [7:0]  data_mask, next_data_mask;
    logic [31:0] polynomial, next_polynomial;
    logic [31:0] lfsr, next_lfsr;
    logic [31:0] rem_mask, next_rem_mask;
    logic [31:0] remainder, next_remainder;
    logic        done, next_done;
    logic [7:0]  masked;
    logic [7:0]  feed;
    logic [31:0] rem_xored;
    logic        crc_start;

    assign INSTR_READY = (state == crc_engine_pkg::ST_IDLE);
    assign INSTR_DONE  = done;
    assign BUSY        = (state == crc_engine_pkg::ST_RUN);
    assign crc_start   = INSTR_VALID && INSTR_READY &&
                         INSTR_WORD[31:24] == `OPCODE_CRC;
    assign fifo_ready  = BUSY;
    assign fifo_fire   = fifo_valid & fifo_ready;
    assign masked      = fifo_item.data ^ data_mask;
    assign feed        = control[`BIT_DATA_REVERSE] ?
                         rev8(masked) : masked;
    assign rem_xored   = lfsr ^ rem_mask;

    always_comb begin
        next_state      = state;
        next_control    = control;
        next_data_mask  = data_mask;
        next_polynomial = polynomial;
        next_lfsr       = lfsr;
        next_rem_mask   = rem_mask;
        next_done       = 1'b0;
        next_remainder  = control[`BIT_REMAINDER_BIT_ORDER_FLIP] ?
                          rev32(rem_xored) : rem_xored;
        if (wr_fire) begin
            unique case (aw_addr)
                `OFS_CRC_CONTROL: next_control = merge(control, w_data, w_strb);
                `OFS_DATA_MASK:   next_data_mask =
                                      w_strb[0] ? w_data[7:0] : data_mask;
                `OFS_POLYNOMIAL:  next_polynomial =
                                      merge(polynomial, w_data, w_strb);
                `OFS_LFSR_STATE:  next_lfsr = merge(lfsr, w_data, w_strb);
                `OFS_REM_MASK:    next_rem_mask = merge(rem_mask, w_data, w_strb);
                default: ;
            endcase
        end
        unique case (state)
            crc_engine_pkg::ST_IDLE: begin
                // State is kept as it stands; no hardware reseed
                if (crc_start) next_state = crc_engine_pkg::ST_RUN;
            end
            crc_engine_pkg::ST_RUN: begin
                // Byte update outranks a concurrent software write
                if (fifo_fire) begin
                    next_lfsr = crc_byte(lfsr, feed, polynomial);
                    if (fifo_item.last) begin
                        next_state = crc_engine_pkg::ST_IDLE;
                        next_done  = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state      <= crc_engine_pkg::ST_IDLE;
            control    <= `RST_CONTROL;
            data_mask  <= `RST_DATA_MASK;
            polynomial <= `RST_POLYNOMIAL;
            lfsr       <= `RST_LFSR_STATE;
            rem_mask   <= `RST_REM_MASK;
            remainder  <= '0;
            done       <= 1'b0;
        end else begin
            state      <= next_state;
            control    <= next_control;
            data_mask  <= next_data_mask;
            polynomial <= next_polynomial;
            lfsr       <= next_lfsr;
            rem_mask   <= next_rem_mask;
            remainder  <= next_remainder;
            done       <= next_done;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    logic        rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  rresp, next_rresp;

    assign ARREADY = !rvalid;
    assign RVALID  = rvalid;
    assign RDATA   = rdata;
    assign RRESP   = rresp;

    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && RREADY) next_rvalid = 1'b0;
        if (ARVALID && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            unique case (ARADDR)
                `OFS_CRC_CONTROL: next_rdata = control;
                `OFS_DATA_MASK:   next_rdata = {24'h0, data_mask};
                `OFS_POLYNOMIAL:  next_rdata = polynomial;
                `OFS_LFSR_STATE:  next_rdata = lfsr;
                `OFS_REM_MASK:    next_rdata = rem_mask;
                `OFS_REMAINDER:   next_rdata = remainder;
                `OFS_STATUS:      next_rdata = {30'h0, fifo_valid, BUSY};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= `RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    start_busy_a: assert property (crc_start |=> BUSY ##0 !INSTR_READY)
        else $error("CRC opcode did not start the engine");
    idle_hold_a: assert property (!BUSY |-> !fifo_ready)
        else $error("Bytes drained while idle");
    last_done_a: assert property (fifo_fire && fifo_item.last
                                  |=> INSTR_DONE && !BUSY ##1 !INSTR_DONE)
        else $error("Last byte did not end the instruction");
    byte_step_a: assert property (fifo_fire && !wr_fire |=> lfsr ==
        crc_byte($past(lfsr), $past(feed), $past(polynomial)))
        else $error("LFSR byte update wrong");
    left_align_a: assert property (fifo_fire && polynomial[15:0] == 16'h0
        && lfsr[15:0] == 16'h0 |=> lfsr[15:0] == 16'h0)
        else $error("Left aligned polynomial touched the low half");
    mask_rev_a: assert property (control[`BIT_DATA_REVERSE] |->
        feed == rev8(fifo_item.data ^ data_mask))
        else $error("Input byte transform wrong");
    state_keep_a: assert property (!BUSY && !wr_fire |=> $stable(lfsr))
        else $error("LFSR changed without cause");
    rem_form_a: assert property (##1 remainder == ($past(control[8]) ?
        rev32($past(lfsr) ^ $past(rem_mask)) :
        $past(lfsr) ^ $past(rem_mask)))
        else $error("Remainder does not follow the state");

    run_cover_c: cover property (crc_start ##[1:40] INSTR_DONE);
    stream_cover_c: cover property (fifo_fire [*4]);
    rev_cover_c: cover property (fifo_fire && control[`BIT_DATA_REVERSE]);

endmodule

// >>> verif/gather_streamer.sv
// Load stream source model standing in for the sequencer's gather streamer
module gather_streamer (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST,
    // Byte stream
    output logic                         BYTE_VALID,
    input  wire logic                    BYTE_READY,
    output crc_engine_pkg::stream_item_t BYTE_ITEM
);
    timeunit 1ns;
    timeprecision 1ps;

    crc_engine_pkg::stream_item_t q[$];
    int                           gap = 0;
    int                           idle = 0;

    // Lowest address first; the gather end is marked on its final byte
    task automatic send_le(input logic [31:0] w, input int n,
                           input logic last);
        for (int i = 0; i < n; i++)
            q.push_back({last && i == n - 1, w[8*i +: 8]});
    endtask

    // Holds a refused byte; idle lines show a changing pattern
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            BYTE_VALID <= 1'b0;
            BYTE_ITEM  <= 9'h000;
        end else if (BYTE_VALID && !BYTE_READY) begin
            BYTE_VALID <= 1'b1;
        end else begin
            if (BYTE_VALID) begin
                void'(q.pop_front());
                idle = gap;
            end
            if (q.size() != 0 && idle == 0) begin
                BYTE_VALID <= 1'b1;
                BYTE_ITEM  <= q[0];
            end else begin
                BYTE_VALID <= 1'b0;
                BYTE_ITEM  <= ~BYTE_ITEM;
                if (idle > 0)
                    idle--;
            end
        end
    end
endmodule

// >>> verif/tb_byte_stream_crc_engine.sv
// Self-checking bench for the byte stream CRC engine
`include "crc_engine_params.svh"

`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("unexpected at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end

module tb_byte_stream_crc_engine;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] poly, seed, rmask;
        logic [7:0]  mask;
        logic        drev, rrev;
    } cfg_t;

    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        instr_valid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, instr_word;
    logic [3:0]  wstrb;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         instr_ready, instr_done, busy, byte_valid, byte_ready;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    crc_engine_pkg::stream_item_t byte_item;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [7:0]  msg[5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
    logic [31:0] std_rem[3] = '{32'h3c4687af, 32'hf8a00000, 32'h000048d0};
    cfg_t        cfgs[4] = '{
        '{32'h04c11db7, 32'hffffffff, 32'hffffffff, 8'h00, 1'b1, 1'b1},
        '{32'h10210000, 32'hffff0000, 32'h00000000, 8'h00, 1'b0, 1'b0},
        '{32'h80050000, 32'hffff0000, 32'h00000000, 8'h00, 1'b1, 1'b1},
        '{32'h07000000, 32'h5a000000, 32'h12345678, 8'h0f, 1'b1, 1'b0}};

    crc_engine DUT (
        .CLK(clk), .RST(rst),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .INSTR_VALID(instr_valid), .INSTR_READY(instr_ready),
        .INSTR_WORD(instr_word), .INSTR_DONE(instr_done), .BUSY(busy),
        .BYTE_VALID(byte_valid), .BYTE_READY(byte_ready),
        .BYTE_ITEM(byte_item)
    );

    gather_streamer src (
        .CLK(clk), .RST(rst), .BYTE_VALID(byte_valid),
        .BYTE_READY(byte_ready), .BYTE_ITEM(byte_item)
    );

    always #20 clk = ~clk;

    // ----
    // Reference model and bus tasks
    // ----
    function automatic logic [31:0] step(input logic [31:0] s,
                                         input logic [7:0] b,
                                         input cfg_t c);
        logic [7:0] d;
        d = b ^ c.mask;
        if (c.drev)
            d = {<<{d}};
        for (int i = 7; i >= 0; i--)
            s = {s[30:0], 1'b0} ^ ((s[31] ^ d[i]) ? c.poly : 32'h0);
        return s;
    endfunction

    function automatic logic [31:0] remainder_value(input logic [31:0] s,
                                        input cfg_t c);
        logic [31:0] r;
        r = s ^ c.rmask;
        if (c.rrev)
            r = {<<{r}};
        return r;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] r);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= v;
        wstrb   <= 4'hf;
        bready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] r);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // Issues one instruction and counts the cycles that show busy
    task automatic run(input logic [7:0] op, output int n);
        int t;
        n = 0;
        t = 0;
        instr_valid <= 1'b1;
        instr_word  <= {op, 24'h000000};
        do @(posedge clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        do begin
            @(posedge clk);
            if (busy === 1'b1)
                n++;
            t++;
        end while (instr_done !== 1'b1 && !(op != `OPCODE_CRC && t == 4));
    endtask

    task automatic setup(input cfg_t c);
        logic [1:0] r;
        wr(`OFS_CRC_CONTROL, {23'h0, c.rrev, 7'h0, c.drev}, r);
        wr(`OFS_DATA_MASK, {24'h0, c.mask}, r);
        wr(`OFS_POLYNOMIAL, c.poly, r);
        wr(`OFS_REM_MASK, c.rmask, r);
        wr(`OFS_LFSR_STATE, c.seed, r);
    endtask

    task automatic results();
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial begin
        logic [31:0] d, s;
        logic [1:0]  r;
        int          n;
        {clk, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wstrb, instr_valid} = 21'h0;
        {wdata, instr_word} = 64'h0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 6; a++) begin
            rd(8'(4 * a), d, r);
            `CHK(d, 32'h0)
        end
        wr(`OFS_DATA_MASK, 32'hffffffff, r);
        rd(`OFS_DATA_MASK, d, r);
        `CHK(d, 32'h000000ff)
        wr(`OFS_REMAINDER, 32'hdeadbeef, r);
        rd(`OFS_REMAINDER, d, r);
        `CHK({d, r}, {32'h0, `RESP_OKAY})
        wr(8'h1c, 32'h1, r);
        `CHK(r, `RESP_SLVERR)
        rd(8'h1c, d, r);
        `CHK({d, r}, {32'h0, `RESP_SLVERR})
        for (int k = 0; k < 4; k++) begin
            s = cfgs[k].seed;
            foreach (msg[i])
                s = step(s, msg[i], cfgs[k]);
            if (k < 3) begin
                src.send_le(32'h78563412, 4, 1'b0);
                src.send_le(32'h9a, 1, 1'b1);
                setup(cfgs[k]);
                run(`OPCODE_CRC, n);
                `CHK(n, 5)
            end else begin
                setup(cfgs[k]);
                src.gap = 3;
                src.send_le(32'h563412, 3, 1'b1);
                run(`OPCODE_CRC, n);
                src.send_le(32'h9a78, 2, 1'b1);
                run(`OPCODE_CRC, n);
                src.gap = 0;
            end
            rd(`OFS_LFSR_STATE, d, r);
            `CHK(d, s)
            rd(`OFS_REMAINDER, d, r);
            `CHK(d, remainder_value(s, cfgs[k]))
            if (k < 3)
                `CHK(d, std_rem[k])
        end
        src.send_le(32'h55, 1, 1'b1);
        run(8'h51, n);
        `CHK(n, 0)
        rd(`OFS_LFSR_STATE, d, r);
        `CHK(d, s)
        run(`OPCODE_CRC, n);
        s = step(s, 8'h55, cfgs[3]);
        for (int i = 0; i < 32; i++) begin
            src.send_le(32'(i * 5 + 3), 1, i == 31);
            s = step(s, 8'(i * 5 + 3), cfgs[3]);
        end
        repeat (40) @(posedge clk);
        `CHK(byte_ready, 1'b0)
        rd(`OFS_STATUS, d, r);
        `CHK(d, 32'h0000_0002)
        run(`OPCODE_CRC, n);
        `CHK(n, `FIFO_DEPTH)
        rd(`OFS_LFSR_STATE, d, r);
        `CHK(d, s)
        results();
    end

    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule
